// file: src/sercfg_regs.vh
`ifndef SERCFG_REGS_VH
`define SERCFG_REGS_VH
// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define SERCFG_IDX_SER_ADDR      5'h00
`define SERCFG_IDX_DES_ADDR      5'h01
`define SERCFG_IDX_SPREAD_RANGE  5'h02
`define SERCFG_IDX_SPREAD_CAL    5'h03
`define SERCFG_IDX_LINK_EN       5'h04
`define SERCFG_IDX_DRIVER        5'h05
`define SERCFG_IDX_RSVD6         5'h06
`define SERCFG_IDX_RSVD7         5'h07
`define SERCFG_IDX_LINE_FAULT    5'h08
`define SERCFG_IDX_RSVD12        5'h0c
`define SERCFG_IDX_INT_MAP_SKEW  5'h0d
`define SERCFG_IDX_IDENTITY      5'h1e
`define SERCFG_IDX_REVISION      5'h1f
// ****************************************
// Reset values
// ****************************************
`define SERCFG_RST_SER_ADDR      8'h80
`define SERCFG_RST_DES_ADDR      8'h90
`define SERCFG_RST_RANGE_LOW     5'h1f
`define SERCFG_RST_SPREAD_OFF    3'h0
`define SERCFG_RST_SPREAD_ON     3'h1
`define SERCFG_RST_SPREAD_CAL    8'h00
`define SERCFG_RST_LINK_LOW      7'h03
`define SERCFG_RST_DRIVER        8'h70
`define SERCFG_RST_RSVD6         8'h40
`define SERCFG_RST_RSVD7         8'h22
`define SERCFG_RST_LINE_FAULT    8'h0a
`define SERCFG_RST_RSVD12        8'h70
`define SERCFG_RST_INT_MAP_SKEW  8'h0f
`define SERCFG_LF_NO_FAULT       2'h2
// ****************************************
// Field positions
// ****************************************
`define SERCFG_BIT_SER_LINK_EN   7
`define SERCFG_BIT_CFG_LINK_EN   6
`define SERCFG_BIT_TEST_PAT_EN   5
`define SERCFG_BIT_SLEEP         4
`define SERCFG_BIT_REV_CH_EN     1
`define SERCFG_BIT_FWD_CH_EN     0
`define SERCFG_BIT_PKT_METHOD    7
`define SERCFG_BIT_FPLL_DIS      6
`define SERCFG_BIT_INT_SET       7
`define SERCFG_BIT_RSVD_BIT_DIS  4
`define SERCFG_BIT_AUDIO_EN      4
`define SERCFG_BIT_RSVD_ADDR     0
// ****************************************
// Timing
// ****************************************
`define SERCFG_STRAP_WAIT        3'h5
`endif

// file: src/sercfg_bank.v
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "sercfg_regs.vh"
module sercfg_bank
#(
   parameter [7:0] IDENTITY_CODE = 8'h5a,   // Arbitrary value
   parameter [3:0] REVISION_CODE = 4'h1     // Arbitrary value
)
(
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Avalon-MM slave
   input  wire [6:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   output reg  [1:0]  avs_response,
   // Strap pins
   input  wire        spread_enable_strap,
   input  wire        autostart_strap,
   input  wire        control_direction_strap,
   // Line fault monitor inputs
   input  wire [1:0]  negative_line_fault,
   input  wire [1:0]  positive_line_fault,
   // Data position 27 sources
   input  wire        reserved_input_bit,
   input  wire        first_aux_control_input,
   output reg         data_position_twenty_seven,
   // Configuration outputs
   output wire [6:0]  serializer_address_field,
   output wire [6:0]  deserializer_address_field,
   output wire [2:0]  spread_setting,
   output wire        audio_channel_enable,
   output wire [1:0]  pixel_clock_range,
   output wire [1:0]  serial_rate_range,
   output wire [1:0]  modulation_rate_calibration,
   output wire [5:0]  sawtooth_divider,
   output wire        sawtooth_auto_cal,
   output wire        serial_link_enable,
   output wire        configuration_link_enable,
   output wire        test_pattern_enable,
   output wire        sleep_mode,
   output wire [1:0]  interface_type,
   output wire        reverse_channel_enable,
   output wire        forward_channel_enable,
   output wire        packet_address_method,
   output wire        filter_pll_disable,
   output wire [1:0]  output_level,
   output wire [3:0]  preemphasis_level,
   output wire        interrupt_set,
   output wire        reserved_bit_disable,
   output wire [3:0]  clock_skew_adjust
);

   // ****************************************
   // Strap and fault input synchronisers
   // ****************************************
   reg  [6:0] sync1_q;
   reg  [6:0] sync2_q;
   reg  [6:0] sync3_q;
   reg  [6:0] stable_q;
   wire [6:0] pin_in;
   // Bit map: 6 direction, 5 autostart, 4 spread, 3:2 and 1:0 fault pairs
   assign pin_in = {control_direction_strap,
                    autostart_strap,
                    spread_enable_strap,
                    negative_line_fault,
                    positive_line_fault};

   // Reset image of the pin stages: fault monitors idle at the no-fault code,
   // so the status register reads clean from reset instead of a false fault
   localparam [6:0] SYNC_RST = {3'h0, `SERCFG_LF_NO_FAULT, `SERCFG_LF_NO_FAULT};

   // Three stages; a change counts only when stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi = gi + 1)
      begin : g_sync
         always @(posedge clk)
         begin
            if (!rst_n)
            begin
               sync1_q[gi]  <= SYNC_RST[gi];
               sync2_q[gi]  <= SYNC_RST[gi];
               sync3_q[gi]  <= SYNC_RST[gi];
               stable_q[gi] <= SYNC_RST[gi];
            end
            else
            begin
               sync1_q[gi] <= pin_in[gi];
               sync2_q[gi] <= sync1_q[gi];
               sync3_q[gi] <= sync2_q[gi];
               // Update only once stages two and three agree, so a pin edge
               // near the clock cannot load a half-settled level
               if (sync2_q[gi] == sync3_q[gi])
                  stable_q[gi] <= sync3_q[gi];
            end
         end
      end
   endgenerate

   // Filtered strap levels
   wire       cds_s   = stable_q[6];
   wire       autostart_strap_s = stable_q[5];
   wire       spread_enable_strap_s  = stable_q[4];

   // ****************************************
   // Strap capture after reset release
   // ****************************************
   // Straps need the synchroniser to fill before the reset values are final,
   // so the bus is held off with waitrequest until capture is done.
   // A strap that moves after capture is ignored until the next reset.
   localparam [2:0] STRAP_WAIT = `SERCFG_STRAP_WAIT;
   reg  [2:0] strap_cnt_q;
   reg        strap_done_q;
   wire       strap_load;
   assign strap_load = !strap_done_q && (strap_cnt_q == STRAP_WAIT);

   // Counter stops once capture is done, so straps are read once per reset
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         strap_cnt_q  <= 3'h0;
         strap_done_q <= 1'b0;
      end
      else if (!strap_done_q)
      begin
         strap_cnt_q  <= strap_cnt_q + 3'h1;
         strap_done_q <= strap_load;
      end
   end

   // ****************************************
   // Register storage
   // ****************************************
   // Writable configuration bytes
   reg  [7:0] ser_addr_q;
   reg  [7:0] des_addr_q;
   reg  [7:0] spread_range_q;
   reg  [7:0] spread_cal_q;
   reg  [7:0] link_en_q;
   reg  [7:0] driver_q;

   // Reserved bytes, writable and read back as stored
   reg  [7:0] rsvd6_q;
   reg  [7:0] rsvd7_q;
   reg  [7:0] rsvd12_q;

   // Interrupt, mapping and skew byte
   reg  [7:0] int_map_q;

   // ****************************************
   // Bus handshake
   // ****************************************
   // Every transfer after strap capture takes one wait state: the first cycle fetches read data
   // and the response into flops, the second drops waitrequest so the master
   // samples them at the very edge that accepts the request. This costs a
   // cycle per access but keeps the data outputs registered.
   localparam [1:0] RESP_OK  = 2'h0;
   localparam [1:0] RESP_ERR = 2'h2;
   wire [4:0] idx;
   wire       req;
   reg        ack_q;
   wire       first_cyc;
   wire       rd_go;
   wire       wr_go;
   wire       wr_b0;

   // Fetch cycle reads; a write lands only on the accepting edge, low lane only
   assign idx       = avs_address[6:2];
   assign req       = (avs_read || avs_write) && strap_done_q;
   assign first_cyc = req && !ack_q;
   assign rd_go     = first_cyc && avs_read;
   assign wr_go     = req && ack_q && avs_write;
   assign wr_b0     = wr_go && avs_byteenable[0];

   // Held off until straps are captured, then one wait state per request
   assign avs_waitrequest = !strap_done_q || ((avs_read || avs_write) && !ack_q);

   // Set on the fetch cycle, cleared again on the accepting edge
   always @(posedge clk)
   begin
      if (!rst_n)
         ack_q <= 1'b0;
      else
         ack_q <= first_cyc;
   end

   // Sleep reset value: wake only when local controller and autostart low
   wire sleep_rst;
   assign sleep_rst = cds_s | autostart_strap_s;

   // Writes, and strap-dependent defaults loaded once at capture
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         ser_addr_q     <= `SERCFG_RST_SER_ADDR;
         des_addr_q     <= `SERCFG_RST_DES_ADDR;
         spread_range_q <= {`SERCFG_RST_SPREAD_OFF, `SERCFG_RST_RANGE_LOW};
         spread_cal_q   <= `SERCFG_RST_SPREAD_CAL;
         link_en_q      <= {1'b0, `SERCFG_RST_LINK_LOW};
         driver_q       <= `SERCFG_RST_DRIVER;
         rsvd6_q        <= `SERCFG_RST_RSVD6;
         rsvd7_q        <= `SERCFG_RST_RSVD7;
         rsvd12_q       <= `SERCFG_RST_RSVD12;
         int_map_q      <= `SERCFG_RST_INT_MAP_SKEW;
      end
      else if (strap_load)
      begin
         // Straps load here only, once per reset
         spread_range_q[7:5] <= spread_enable_strap_s ? `SERCFG_RST_SPREAD_ON
                                       : `SERCFG_RST_SPREAD_OFF;
         link_en_q[`SERCFG_BIT_SER_LINK_EN] <= !autostart_strap_s;
         link_en_q[`SERCFG_BIT_SLEEP]       <= sleep_rst;
      end
      else if (wr_b0)
      begin
         case (idx)
            `SERCFG_IDX_SER_ADDR:     ser_addr_q <= {avs_writedata[7:1], 1'b0};
            `SERCFG_IDX_DES_ADDR:     des_addr_q <= {avs_writedata[7:1], 1'b0};
            `SERCFG_IDX_SPREAD_RANGE: spread_range_q <= avs_writedata[7:0];
            `SERCFG_IDX_SPREAD_CAL:   spread_cal_q   <= avs_writedata[7:0];
            `SERCFG_IDX_LINK_EN:      link_en_q      <= avs_writedata[7:0];
            `SERCFG_IDX_DRIVER:       driver_q       <= avs_writedata[7:0];
            `SERCFG_IDX_RSVD6:        rsvd6_q        <= avs_writedata[7:0];
            `SERCFG_IDX_RSVD7:        rsvd7_q        <= avs_writedata[7:0];
            `SERCFG_IDX_RSVD12:       rsvd12_q       <= avs_writedata[7:0];
            `SERCFG_IDX_INT_MAP_SKEW: int_map_q      <= avs_writedata[7:0];
            // Holes and read-only offsets store nothing
            default:                  ser_addr_q     <= ser_addr_q;
         endcase
      end
   end

   // ****************************************
   // Line fault status and read mux
   // ****************************************
   // Fault fields come straight from the filtered monitor inputs
   // Upper nibble is reserved and reads zero
   wire [7:0] line_fault;
   assign line_fault = {4'h0, stable_q[3:2], stable_q[1:0]};

   reg  [7:0] rd_byte;
   reg        rd_hit;
   // Read mux; a hole drops rd_hit for the error response
   always @*
   begin
      rd_hit  = 1'b1;
      rd_byte = 8'h00;
      case (idx)
         `SERCFG_IDX_SER_ADDR:     rd_byte = ser_addr_q;
         `SERCFG_IDX_DES_ADDR:     rd_byte = des_addr_q;
         `SERCFG_IDX_SPREAD_RANGE: rd_byte = spread_range_q;
         `SERCFG_IDX_SPREAD_CAL:   rd_byte = spread_cal_q;
         `SERCFG_IDX_LINK_EN:      rd_byte = link_en_q;
         `SERCFG_IDX_DRIVER:       rd_byte = driver_q;
         `SERCFG_IDX_RSVD6:        rd_byte = rsvd6_q;
         `SERCFG_IDX_RSVD7:        rd_byte = rsvd7_q;
         `SERCFG_IDX_LINE_FAULT:   rd_byte = line_fault;
         `SERCFG_IDX_RSVD12:       rd_byte = rsvd12_q;
         `SERCFG_IDX_INT_MAP_SKEW: rd_byte = int_map_q;
         `SERCFG_IDX_IDENTITY:     rd_byte = IDENTITY_CODE;
         `SERCFG_IDX_REVISION:     rd_byte = {4'h0, REVISION_CODE};
         default:                  rd_hit  = 1'b0;
      endcase
   end

   // Read data and response are registered on the fetch cycle and stand
   // through the accepting edge. Unmapped offsets answer with an error
   // response so software can tell a hole from a zero. Read-only targets
   // accept writes silently rather than flag an error.
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         avs_readdata <= 32'h0;
         avs_response <= RESP_OK;
      end
      else if (rd_go)
      begin
         avs_readdata <= {24'h0, rd_byte};
         avs_response <= rd_hit ? RESP_OK : RESP_ERR;
      end
      else if (first_cyc)
      begin
         // Write response: same decode, set before the write lands
         avs_response <= rd_hit ? RESP_OK : RESP_ERR;
      end
   end

   // ****************************************
   // Data position 27 mapping
   // ****************************************
   // One flop between the chosen source and the lane; the switch follows
   // the disable bit one cycle after the write lands
   always @(posedge clk)
   begin
      if (!rst_n)
         data_position_twenty_seven <= 1'b0;
      else if (int_map_q[`SERCFG_BIT_RSVD_BIT_DIS])
         data_position_twenty_seven <= first_aux_control_input;
      else
         data_position_twenty_seven <= reserved_input_bit;
   end

   // ****************************************
   // Field outputs
   // ****************************************
   // Fields are plain views of the flops, no extra decode delay
   // Device addresses, reserved bit 0 dropped
   assign serializer_address_field    = ser_addr_q[7:1];
   assign deserializer_address_field  = des_addr_q[7:1];

   // Spread, audio and range detection
   assign spread_setting              = spread_range_q[7:5];
   assign audio_channel_enable        = spread_range_q[`SERCFG_BIT_AUDIO_EN];
   assign pixel_clock_range           = spread_range_q[3:2];
   assign serial_rate_range           = spread_range_q[1:0];

   // Spread calibration
   assign modulation_rate_calibration = spread_cal_q[7:6];
   assign sawtooth_divider            = spread_cal_q[5:0];
   assign sawtooth_auto_cal           = (spread_cal_q[5:0] == 6'h00);

   // Link, sleep and control channel enables
   assign serial_link_enable          = link_en_q[`SERCFG_BIT_SER_LINK_EN];
   assign configuration_link_enable   = link_en_q[`SERCFG_BIT_CFG_LINK_EN];
   assign test_pattern_enable         = link_en_q[`SERCFG_BIT_TEST_PAT_EN];
   assign sleep_mode                  = link_en_q[`SERCFG_BIT_SLEEP];
   assign interface_type              = link_en_q[3:2];
   assign reverse_channel_enable      = link_en_q[`SERCFG_BIT_REV_CH_EN];
   assign forward_channel_enable      = link_en_q[`SERCFG_BIT_FWD_CH_EN];

   // Packet method, filter PLL and output driver
   assign packet_address_method       = driver_q[`SERCFG_BIT_PKT_METHOD];
   assign filter_pll_disable          = driver_q[`SERCFG_BIT_FPLL_DIS];
   assign output_level                = driver_q[5:4];
   assign preemphasis_level           = driver_q[3:0];

   // Interrupt, position 27 mapping and skew
   assign interrupt_set               = int_map_q[`SERCFG_BIT_INT_SET];
   assign reserved_bit_disable        = int_map_q[`SERCFG_BIT_RSVD_BIT_DIS];
   assign clock_skew_adjust           = int_map_q[3:0];

endmodule

// file: dv/sercfg_host.sv
`timescale 1ns/1ps
// ****
// Bus master model of the controller
// ****
module sercfg_host
(
   // Clock
   input  wire        clk,
   // Avalon-MM master side
   output reg  [6:0]  avs_address,
   output reg         avs_read,
   output reg         avs_write,
   output reg  [31:0] avs_writedata,
   output reg  [3:0]  avs_byteenable,
   input  wire [31:0] avs_readdata,
   input  wire        avs_waitrequest,
   input  wire [1:0]  avs_response
);
   // Idle bus from time zero
   initial
   begin
      avs_address = 7'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
   end
   // One transfer; read data and response are taken at the accepting edge
   task xfer(input bit wr, input [4:0] idx, input [7:0] wd, input [3:0] be,
             output [7:0] rd, output [1:0] rsp);
      begin
         avs_address <= {idx, 2'h0};
         avs_writedata <= {24'h0, wd};
         avs_byteenable <= be;
         avs_write <= wr;
         avs_read <= ~wr;
         @(posedge clk);
         while (avs_waitrequest)
            @(posedge clk);
         rd = avs_readdata[7:0];
         rsp = avs_response;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         @(posedge clk);
      end
   endtask
endmodule

// file: dv/sercfg_props.sv
`timescale 1ns/1ps
// ****
// Register bank checker
// ****
module sercfg_props
(
   // Clock and reset
   input wire        clk,
   input wire        rst_n,
   // Bus
   input wire [6:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0]  avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire [1:0]  avs_response,
   // Fields
   input wire        reserved_input_bit,
   input wire        first_aux_control_input,
   input wire        data_position_twenty_seven,
   input wire        reserved_bit_disable,
   input wire [6:0]  serializer_address_field,
   input wire [5:0]  sawtooth_divider,
   input wire        sawtooth_auto_cal
);
   // Accepted request, index and unmapped holes of the map
   wire       acc = (avs_read | avs_write) & ~avs_waitrequest;
   wire [4:0] idx = avs_address[6:2];
   wire       bad = (idx > 5'h08 && idx < 5'h0c) || (idx > 5'h0d && idx < 5'h1e);
   wire       wr0 = acc & avs_write & avs_byteenable[0];
   wire [6:0] wd_hi = avs_writedata[7:1];
   wire       wd4 = avs_writedata[4];
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   d27_map_a: assert property (
      $past(rst_n) |-> data_position_twenty_seven == ($past(reserved_bit_disable) ?
      $past(first_aux_control_input) : $past(reserved_input_bit))) else $error("d27 source");
   saw_auto_a: assert property (
      sawtooth_auto_cal == (sawtooth_divider == 6'h00)) else $error("auto cal flag");
   err_rsp_a: assert property (
      acc && bad |-> avs_response == 2'h2) else $error("no error response");
   ok_rsp_a: assert property (
      acc && !bad |-> avs_response == 2'h0) else $error("bad ok response");
   addr_bit0_a: assert property (
      acc && avs_read && idx < 5'h02 |-> avs_readdata[0] == 1'b0) else $error("addr bit0");
   rev_hi_a: assert property (
      acc && avs_read && idx == 5'h1f |-> avs_readdata[7:4] == 4'h0) else $error("rev nibble");
   ser_addr_a: assert property (
      wr0 && idx == 5'h00 |=> serializer_address_field == $past(wd_hi)) else $error("ser addr");
   hold_addr_a: assert property (
      acc && avs_write && !avs_byteenable[0] && idx == 5'h00 |=>
      $stable(serializer_address_field)) else $error("masked write stored");
   map_wr_a: assert property (
      wr0 && idx == 5'h0d |=> reserved_bit_disable == $past(wd4)) else $error("map bit");
   ready_a: assert property (
      $rose(rst_n) |-> ##[1:8] !avs_waitrequest) else $error("never ready");
   // Main scenarios
   cover property (acc && bad);
   cover property (wr0 && idx == 5'h0d);
   cover property (acc && avs_read && idx == 5'h1f);
endmodule
bind sercfg_bank sercfg_props u_props (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
   .reserved_input_bit(reserved_input_bit), .first_aux_control_input(first_aux_control_input),
   .data_position_twenty_seven(data_position_twenty_seven),
   .reserved_bit_disable(reserved_bit_disable), .serializer_address_field(serializer_address_field),
   .sawtooth_divider(sawtooth_divider), .sawtooth_auto_cal(sawtooth_auto_cal));

// file: dv/sercfg_bank_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
// ****
// Register bank testbench
// ****
module sercfg_bank_tb;
   reg clk, rst_n, ss, au, cd, res, aux;
   reg [1:0] lfn, lfp;
   wire [6:0] adr;
   wire [31:0] wdat, rdat;
   wire [3:0] be;
   wire [1:0] resp;
   wire rd_r, wr_r, wreq, d27, iset;
   wire [6:0] ser_f;
   wire [2:0] spr;
   wire [3:0] skew;
   wire [37:0] fv;   // Field outputs packed in register order
   int err_total, cmp_count, i;
   reg [31:0] rows [0:19];
   reg [31:0] r;
   reg [7:0] rd;
   reg [1:0] rsp;
   reg [37:0] fx;
   // Identity values are arbitrary
   sercfg_bank #(.IDENTITY_CODE(8'h3c), .REVISION_CODE(4'h9)) DUT (.clk(clk), .rst_n(rst_n),
      .avs_address(adr), .avs_read(rd_r), .avs_write(wr_r), .avs_writedata(wdat),
      .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq), .avs_response(resp),
      .spread_enable_strap(ss), .autostart_strap(au), .control_direction_strap(cd),
      .negative_line_fault(lfn), .positive_line_fault(lfp), .reserved_input_bit(res),
      .first_aux_control_input(aux), .data_position_twenty_seven(d27),
      .serializer_address_field(ser_f), .deserializer_address_field(fv[37:31]),
      .spread_setting(spr), .audio_channel_enable(fv[30]), .pixel_clock_range(fv[29:28]),
      .serial_rate_range(fv[27:26]), .modulation_rate_calibration(fv[25:24]),
      .sawtooth_divider(fv[23:18]), .sawtooth_auto_cal(fv[17]),
      .serial_link_enable(fv[16]), .configuration_link_enable(fv[15]),
      .test_pattern_enable(fv[14]), .sleep_mode(fv[13]), .interface_type(fv[12:11]),
      .reverse_channel_enable(fv[10]), .forward_channel_enable(fv[9]),
      .packet_address_method(fv[8]), .filter_pll_disable(fv[7]), .output_level(fv[6:5]),
      .preemphasis_level(fv[4:1]), .interrupt_set(iset), .reserved_bit_disable(fv[0]),
      .clock_skew_adjust(skew));
   sercfg_host u_host (.clk(clk), .avs_address(adr), .avs_read(rd_r), .avs_write(wr_r),
      .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wreq), .avs_response(resp));
   // Verdict and end of run
   task stop_test;
      begin
         if (err_total == 0 && cmp_count > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // Free-running clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard, well beyond the 150 or so cycles the tests need
   initial
   begin
      #300000;
      err_total++;
      stop_test;
   end
   // Main sequence; row = index, write flag, response, write data, read-back
   initial
   begin
      rst_n = 1'b0; ss = 1'b1; au = 1'b0; cd = 1'b0; res = 1'b0; aux = 1'b0;
      lfn = 2'b10; lfp = 2'b10;
      rows = '{32'h00000080, 32'h01000090,
               32'h0200003f, 32'h03000000,
               32'h04000083, 32'h05000070,
               32'h06000040, 32'h07000022, 32'h0800000a, 32'h0c000070,
               32'h0d00000f, 32'h1e00003c, 32'h1f000009,
               32'h0010a5a4, 32'h01103332,
               32'h0810ff0a, 32'h1e10003c, 32'h0d109090,
               32'h0a125500, 32'h06104040};
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         r = rows[i];
         if (r[20])
         begin
            u_host.xfer(1'b1, r[28:24], r[15:8], 4'h1, rd, rsp);
            `CHK("wr_rsp", r[17:16], rsp)
         end
         u_host.xfer(1'b0, r[28:24], 8'h00, 4'h1, rd, rsp);
         `CHK("rd_rsp", r[17:16], rsp)
         if (r[17:16] == 2'h0)
            `CHK("rd_data", r[7:0], rd)
      end
      // Masked write must not land
      u_host.xfer(1'b1, 5'h00, 8'hff, 4'h0, rd, rsp);
      u_host.xfer(1'b0, 5'h00, 8'h00, 4'h1, rd, rsp);
      `CHK("masked", 8'ha4, rd)
      `CHK("ser_field", 7'h52, ser_f)
      `CHK("int_set", 1'b1, iset)
      fx = {7'h19, 1'b1, 2'h3, 2'h3, 2'h0, 6'h00, 1'b1, 8'h83, 8'h70, 1'b1};
      `CHK("fields", fx, fv)
      // Position 27 source follows the disable bit
      aux <= 1'b1;
      repeat (2) @(posedge clk);
      #1 `CHK("d27_aux", 1'b1, d27)
      @(posedge clk);
      u_host.xfer(1'b1, 5'h0d, 8'h0f, 4'h1, rd, rsp);
      repeat (2) @(posedge clk);
      #1 `CHK("d27_res", 1'b0, d27)
      `CHK("skew", 4'hf, skew)
      // Live fault status
      @(posedge clk);
      lfn <= 2'b01;
      lfp <= 2'b11;
      repeat (10) @(posedge clk);
      u_host.xfer(1'b0, 5'h08, 8'h00, 4'h1, rd, rsp);
      `CHK("fault", 8'h07, rd)
      // Programmed calibration turns the automatic divider off
      u_host.xfer(1'b1, 5'h03, 8'h45, 4'h1, rd, rsp);
      `CHK("cal", {2'h1, 6'h05, 1'b0}, fv[25:17])
      // Second reset with opposite spread and autostart straps
      rst_n <= 1'b0; ss <= 1'b0; au <= 1'b1;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      u_host.xfer(1'b0, 5'h02, 8'h00, 4'h1, rd, rsp);
      `CHK("spread", 8'h1f, rd)
      `CHK("spread_out", 3'h0, spr)
      u_host.xfer(1'b0, 5'h04, 8'h00, 4'h1, rd, rsp);
      `CHK("link", 8'h13, rd)
      u_host.xfer(1'b0, 5'h00, 8'h00, 4'h1, rd, rsp);
      `CHK("ser_rst", 8'h80, rd)
      fx = {7'h48, 1'b1, 2'h3, 2'h3, 2'h0, 6'h00, 1'b1, 8'h13, 8'h70, 1'b0};
      `CHK("fields_rst", fx, fv)
      stop_test;
   end
endmodule
